// ### cpu_status_pkg.sv
package cpu_status_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int BUS_W  = 32;
    localparam int ADR_W  = 4;
    localparam int SEL_W  = BUS_W / 8;
    localparam int WORD_W = 16;

    // byte addresses of the three registers
    localparam logic [ADR_W-1:0] OFS_STATUS    = 4'h0;
    localparam logic [ADR_W-1:0] OFS_CORE_CTRL = 4'h4;
    localparam logic [ADR_W-1:0] OFS_INT_CTRL1 = 4'h8;

    // ------------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------------
    localparam int BIT_CARRY = 0;
    localparam int BIT_ZERO  = 1;
    localparam int BIT_OVF   = 2;
    localparam int BIT_NEG   = 3;
    localparam int BIT_LOOP  = 4;
    localparam int PRI_LSB   = 5;
    localparam int PRI_MSB   = 7;
    localparam int BIT_SAB   = 10;
    localparam int BIT_SB    = 12;
    localparam int BIT_SA    = 13;

    // core control and interrupt control one layout
    localparam int BIT_PRI_HIGH = 3;
    localparam int BIT_NEST_DIS = 15;

    // priority field
    localparam int                 PRI_W        = PRI_MSB - PRI_LSB + 1;
    localparam logic [PRI_W-1:0]   PRI_MASK_ALL = 3'h7;
    localparam logic [PRI_W-1:0]   PRI_RST      = 3'h0;
    localparam logic [PRI_W:0]     EFF_HIGH_MIN = 4'h8;

    // byte lanes that carry the low and high status byte
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // reset values of the stored bits
    localparam logic FLAG_RST    = 1'b0;
    localparam logic CTRL_BIT_RST = 1'b0;

endpackage

// ### cpu_flag_eval.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// flag evaluation of one alu result
// ----------------------------------------------------------------------
module cpu_flag_eval #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] op_a,
    input  wire logic [WIDTH-1:0] op_b,
    input  wire logic [WIDTH-1:0] result,
    input  wire logic             carry_out,
    input  wire logic             is_sub,
    output logic                  negative,
    output logic                  overflow,
    output logic                  zero,
    output logic                  carry
);

    // refused at elaboration: a one-bit result has no separate sign bit
    if (WIDTH < 2) begin
        $error("cpu_flag_eval needs at least two result bits");
    end

    logic sign_a;
    logic sign_b;
    logic sign_r;

    // sign bits of both operands and the result
    assign sign_a = op_a[WIDTH-1];
    assign sign_b = op_b[WIDTH-1];
    assign sign_r = result[WIDTH-1];

    // result sign decides the negative flag
    assign negative = sign_r;

    // subtract flips the second operand's sign before the same test
    assign overflow = ((sign_a == (sign_b ^ is_sub)) && (sign_r != sign_a));

    assign zero  = (result == '0);
    assign carry = carry_out;

endmodule

// ### cpu_status_flags.sv
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module cpu_status_flags
    import cpu_status_pkg::*;
#(
    parameter int ALU_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [SEL_W-1:0] wb_sel_i,
    input  wire logic [BUS_W-1:0] wb_dat_i,
    output logic      [BUS_W-1:0] wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             alu_valid,
    input  wire logic [ALU_W-1:0] alu_op_a,
    input  wire logic [ALU_W-1:0] alu_op_b,
    input  wire logic [ALU_W-1:0] alu_result,
    input  wire logic             alu_carry_out,
    input  wire logic             alu_is_sub,
    input  wire logic             alu_upd_neg,
    input  wire logic             alu_upd_ovf,
    input  wire logic             alu_upd_zero,
    input  wire logic             alu_upd_carry,
    input  wire logic             alu_zero_sticky,
    input  wire logic             loop_running,
    input  wire logic             pri_load,
    input  wire logic [PRI_W-1:0] pri_value,
    input  wire logic             sat_a_set,
    input  wire logic             sat_b_set,
    output logic      [WORD_W-1:0] cpu_status_word,
    output logic      [PRI_W:0]   effective_priority,
    output logic                  user_irq_blocked
);

    // refused at elaboration, the flag logic needs a sign bit
    if (ALU_W < 2) begin
        $error("cpu_status_flags needs an alu of two bits or more");
    end

    // ------------------------------------------------------------------
    // stored state
    // ------------------------------------------------------------------
    logic             flag_carry;
    logic             flag_zero;
    logic             signed_overflow_flag;
    logic             flag_neg;
    logic             loop_active_flag;
    logic [PRI_W-1:0] priority_level_field;
    logic             accum_a_saturated;
    logic             accum_b_saturated;
    logic             priority_high_bit;
    logic             nesting_disable_bit;
    logic             ev_neg;
    logic             ev_ovf;
    logic             ev_zero;
    logic             ev_carry;
    logic             bus_req;
    logic             commit;
    logic             wr_status_lo;
    logic             wr_status_hi;
    logic             wr_core_ctrl;
    logic             wr_int_ctrl1;
    logic             combined_saturation_bit;
    logic             sab_clear;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // one compare shared by the write strobes and the read mux
    function automatic logic addr_hit(input logic [ADR_W-1:0] adr,
                                      input logic [ADR_W-1:0] ofs);
        addr_hit = (adr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // alu flag evaluation
    // ------------------------------------------------------------------
    cpu_flag_eval #(
        .WIDTH     (ALU_W)
    ) u_flag_eval (
        .op_a      (alu_op_a),
        .op_b      (alu_op_b),
        .result    (alu_result),
        .carry_out (alu_carry_out),
        .is_sub    (alu_is_sub),
        .negative  (ev_neg),
        .overflow  (ev_ovf),
        .zero      (ev_zero),
        .carry     (ev_carry)
    );

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    // a write lands on the edge where the master sees ack, never earlier
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign commit  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // write strobes per register and byte lane
    assign wr_status_lo = commit && addr_hit(wb_adr_i, OFS_STATUS)
                          && wb_sel_i[LANE_LO];
    assign wr_status_hi = commit && addr_hit(wb_adr_i, OFS_STATUS)
                          && wb_sel_i[LANE_HI];
    assign wr_core_ctrl = commit && addr_hit(wb_adr_i, OFS_CORE_CTRL)
                          && wb_sel_i[LANE_LO];
    assign wr_int_ctrl1 = commit && addr_hit(wb_adr_i, OFS_INT_CTRL1)
                          && wb_sel_i[LANE_HI];

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read data captured with the ack; unmapped addresses read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_dat_o <= '0;
        end else if (bus_req) begin
            wb_dat_o <= '0;
            if (addr_hit(wb_adr_i, OFS_STATUS)) begin
                wb_dat_o[WORD_W-1:0] <= cpu_status_word;
            end else if (addr_hit(wb_adr_i, OFS_CORE_CTRL)) begin
                wb_dat_o[BIT_PRI_HIGH] <= priority_high_bit;
            end else if (addr_hit(wb_adr_i, OFS_INT_CTRL1)) begin
                wb_dat_o[BIT_NEST_DIS] <= nesting_disable_bit;
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            priority_high_bit <= CTRL_BIT_RST;
        end else if (wr_core_ctrl) begin
            priority_high_bit <= wb_dat_i[BIT_PRI_HIGH];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nesting_disable_bit <= CTRL_BIT_RST;
        end else if (wr_int_ctrl1) begin
            nesting_disable_bit <= wb_dat_i[BIT_NEST_DIS];
        end
    end

    // ------------------------------------------------------------------
    // alu flags
    // ------------------------------------------------------------------
    // hardware updates win over a software write in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_carry <= FLAG_RST;
        end else if (alu_valid && alu_upd_carry) begin
            flag_carry <= ev_carry;
        end else if (wr_status_lo) begin
            flag_carry <= wb_dat_i[BIT_CARRY];
        end
    end
    // sticky mode lets a zero result leave the bit as it was
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_zero <= FLAG_RST;
        end else if (alu_valid && alu_upd_zero) begin
            if (!ev_zero) begin
                flag_zero <= 1'b0;
            end else if (!alu_zero_sticky) begin
                flag_zero <= 1'b1;
            end
        end else if (wr_status_lo) begin
            flag_zero <= wb_dat_i[BIT_ZERO];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            signed_overflow_flag <= FLAG_RST;
        end else if (alu_valid && alu_upd_ovf) begin
            signed_overflow_flag <= ev_ovf;
        end else if (wr_status_lo) begin
            signed_overflow_flag <= wb_dat_i[BIT_OVF];
        end
    end
    // untouched flags simply hold, no default reload
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_neg <= FLAG_RST;
        end else if (alu_valid && alu_upd_neg) begin
            flag_neg <= ev_neg;
        end else if (wr_status_lo) begin
            flag_neg <= wb_dat_i[BIT_NEG];
        end
    end

    // ------------------------------------------------------------------
    // loop activity and priority
    // ------------------------------------------------------------------
    // read-only for software; mirrors the sequencer one cycle later
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            loop_active_flag <= FLAG_RST;
        end else begin
            loop_active_flag <= loop_running;
        end
    end
    // interrupt logic always gets its level in, software only if allowed
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            priority_level_field <= PRI_RST;
        end else if (pri_load) begin
            priority_level_field <= pri_value;
        end else if (wr_status_lo && !nesting_disable_bit) begin
            priority_level_field <= wb_dat_i[PRI_MSB:PRI_LSB];
        end
    end
    // effective level and user interrupt gate
    assign effective_priority = {priority_high_bit,
                                 priority_level_field};
    assign user_irq_blocked   = priority_high_bit ||
                                (priority_level_field == PRI_MASK_ALL);

    // ------------------------------------------------------------------
    // saturation bits
    // ------------------------------------------------------------------
    // clearing sab means writing zero to it while it reads one, so a
    // plain read-back of the word never wipes a fresh saturation
    assign combined_saturation_bit = accum_a_saturated || accum_b_saturated;
    assign sab_clear = wr_status_hi && combined_saturation_bit
                       && !wb_dat_i[BIT_SAB];
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accum_a_saturated <= FLAG_RST;
        end else if (sat_a_set) begin
            accum_a_saturated <= 1'b1;
        end else if (sab_clear) begin
            accum_a_saturated <= 1'b0;
        end else if (wr_status_hi) begin
            accum_a_saturated <= wb_dat_i[BIT_SA];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            accum_b_saturated <= FLAG_RST;
        end else if (sat_b_set) begin
            accum_b_saturated <= 1'b1;
        end else if (sab_clear) begin
            accum_b_saturated <= 1'b0;
        end else if (wr_status_hi) begin
            accum_b_saturated <= wb_dat_i[BIT_SB];
        end
    end

    // ------------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------------
    always_comb begin
        cpu_status_word                  = '0;
        cpu_status_word[BIT_CARRY]       = flag_carry;
        cpu_status_word[BIT_ZERO]        = flag_zero;
        cpu_status_word[BIT_OVF]         = signed_overflow_flag;
        cpu_status_word[BIT_NEG]         = flag_neg;
        cpu_status_word[BIT_LOOP]        = loop_active_flag;
        cpu_status_word[PRI_MSB:PRI_LSB] = priority_level_field;
        cpu_status_word[BIT_SAB]         = combined_saturation_bit;
        cpu_status_word[BIT_SB]          = accum_b_saturated;
        cpu_status_word[BIT_SA]          = accum_a_saturated;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence seq_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence seq_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence seq_sw_pri_write;
        wr_status_lo && !pri_load;
    endsequence

    AST_WB_ACK_ONE_CYCLE:
    assert property (seq_bus_req |-> ##1 seq_ack_pulse)
        else $error("ack not a single pulse one cycle after request");
    AST_PRI_LOCKED:
    assert property (seq_sw_pri_write ##0 nesting_disable_bit
                     |=> $stable(priority_level_field))
        else $error("priority field changed while nesting disabled");
    AST_PRI_WRITTEN:
    assert property (seq_sw_pri_write ##0 !nesting_disable_bit
                     |=> priority_level_field
                         == $past(wb_dat_i[PRI_MSB:PRI_LSB]))
        else $error("software priority write lost");
    AST_HIGH_LEVEL:
    assert property (priority_high_bit
                     |-> effective_priority == EFF_HIGH_MIN
                         + (PRI_W+1)'(priority_level_field))
        else $error("effective level is not the field plus eight");
    AST_HIGH_BLOCKS:
    assert property (priority_high_bit |-> user_irq_blocked)
        else $error("user interrupts open with high priority bit");
    AST_TOP_BLOCKS:
    assert property (!priority_high_bit && !user_irq_blocked
                     |-> priority_level_field != PRI_MASK_ALL)
        else $error("level seven did not block user interrupts");
    AST_LOOP_TRACK:
    assert property (loop_running ##1 !loop_running
                     |-> loop_active_flag ##1 !loop_active_flag)
        else $error("loop active bit did not follow the loop");
    AST_NEG_FOLLOWS:
    assert property (alu_valid && alu_upd_neg
                     |=> flag_neg == $past(alu_result[ALU_W-1]))
        else $error("negative flag does not match result sign");
    AST_OVF_ADD:
    assert property (alu_valid && alu_upd_ovf && !alu_is_sub
                     && alu_op_a[ALU_W-1] == alu_op_b[ALU_W-1]
                     && alu_result[ALU_W-1] != alu_op_a[ALU_W-1]
                     |=> signed_overflow_flag)
        else $error("signed add overflow not flagged");
    AST_ZERO_STICKY:
    assert property (flag_zero && !wr_status_lo
                     && !(alu_valid && alu_upd_zero && !ev_zero)
                     |=> flag_zero)
        else $error("zero flag dropped without a non-zero result");
    AST_CARRY_FOLLOWS:
    assert property (alu_valid && alu_upd_carry
                     |=> flag_carry == $past(alu_carry_out))
        else $error("carry flag does not match carry out");
    AST_SAB_CLEARS:
    assert property (sab_clear && !sat_a_set && !sat_b_set
                     |=> !accum_a_saturated && !accum_b_saturated)
        else $error("sab clear left a saturation bit set");
    AST_FLAGS_HOLD:
    assert property (!alu_valid && !wr_status_lo
                     |=> $stable({flag_carry, flag_zero,
                                  signed_overflow_flag, flag_neg}))
        else $error("alu flag moved with no update");

endmodule

// ### cpu_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far side: alu, repeat sequencer and interrupt logic
// ------------------------------------------------------------------
module cpu_core_model
    import cpu_status_pkg::*;
(
    input  wire logic         sys_clk,
    output logic              alu_valid,
    output logic [15:0]       alu_op_a,
    output logic [15:0]       alu_op_b,
    output logic [15:0]       alu_result,
    output logic              alu_carry_out,
    output logic              alu_is_sub,
    output logic [3:0]        alu_upd,
    output logic              alu_zero_sticky,
    output logic              loop_running,
    output logic              pri_load,
    output logic [PRI_W-1:0]  pri_value,
    output logic              sat_a_set,
    output logic              sat_b_set
);
    // quiet start, every strobe low
    initial begin
        {alu_valid, alu_carry_out, alu_is_sub, alu_zero_sticky} = 4'h0;
        {alu_op_a, alu_op_b, alu_result, alu_upd} = 52'h0;
        {loop_running, pri_load, pri_value, sat_a_set, sat_b_set} = 7'h0;
    end

    // one flag-affecting instruction; operands turn to junk afterwards
    // so a design that samples outside alu_valid is caught
    task automatic alu(input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] r, input logic co,
                       input logic sub, input logic [3:0] upd,
                       input logic st);
        @(posedge sys_clk);
        alu_valid       <= 1'b1;
        {alu_op_a, alu_op_b, alu_result} <= {a, b, r};
        {alu_carry_out, alu_is_sub, alu_zero_sticky} <= {co, sub, st};
        alu_upd         <= upd;
        @(posedge sys_clk);
        alu_valid       <= 1'b0;
        {alu_op_a, alu_op_b, alu_result} <= ~{a, b, r};
        alu_upd         <= ~upd;
    endtask

    // repeat loop in progress, a level
    task automatic loop(input logic on);
        @(posedge sys_clk);
        loop_running <= on;
    endtask

    // priority load and saturation set are one-cycle pulses
    task automatic hw(input logic pl, input logic [PRI_W-1:0] pv,
                      input logic sa, input logic sb);
        @(posedge sys_clk);
        {pri_load, pri_value, sat_a_set, sat_b_set} <= {pl, pv, sa, sb};
        @(posedge sys_clk);
        {pri_load, pri_value, sat_a_set, sat_b_set} <= {1'b0, ~pv, 2'h0};
    endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb
    import cpu_status_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [ADR_W-1:0]  wb_adr_i = 4'h0;
    logic [SEL_W-1:0]  wb_sel_i = 4'h0;
    logic [BUS_W-1:0]  wb_dat_i = 32'h0;
    logic [BUS_W-1:0]  wb_dat_o;
    logic              wb_ack_o, alu_valid, alu_carry_out, alu_is_sub;
    logic [15:0]       alu_op_a, alu_op_b, alu_result;
    logic [3:0]        alu_upd;
    logic              alu_zero_sticky, loop_running, pri_load;
    logic [PRI_W-1:0]  pri_value;
    logic              sat_a_set, sat_b_set, user_irq_blocked;
    logic [WORD_W-1:0] cpu_status_word;
    logic [PRI_W:0]    effective_priority;
    logic [15:0]       ex;
    int                failures = 0;
    int                n_compared = 0;
    localparam logic [15:0] TA [4] = '{16'h7FFF, 16'hFFFF, 16'h8000, 16'h5};
    localparam logic [15:0] TB [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h5};
    localparam logic [15:0] TR [4] = '{16'h8000, 16'h0000, 16'h7FFF, 16'h0};
    localparam logic [3:0]  TC = 4'b1110;
    localparam logic [3:0]  TS = 4'b1100;

    always #2.5 sys_clk = ~sys_clk;

    cpu_status_flags uut (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .alu_valid, .alu_op_a, .alu_op_b, .alu_result, .alu_carry_out,
        .alu_is_sub, .alu_upd_neg(alu_upd[3]), .alu_upd_ovf(alu_upd[2]),
        .alu_upd_zero(alu_upd[1]), .alu_upd_carry(alu_upd[0]),
        .alu_zero_sticky, .loop_running, .pri_load, .pri_value,
        .sat_a_set, .sat_b_set, .cpu_status_word, .effective_priority,
        .user_irq_blocked);

    cpu_core_model core (.sys_clk, .alu_valid, .alu_op_a, .alu_op_b,
        .alu_result, .alu_carry_out, .alu_is_sub, .alu_upd,
        .alu_zero_sticky, .loop_running, .pri_load, .pri_value,
        .sat_a_set, .sat_b_set);

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // let the edge's updates land before looking
    task automatic chk_sw();
        @(negedge sys_clk);
        chk("status", 32'(ex), 32'(cpu_status_word));
    endtask

    // classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) failures++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, s, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 4'hF, 32'h0, q);
        chk("read", e, q);
    endtask

    // flags from the result, operands and carry vectors: {n, ov, z, c}
    function automatic logic [3:0] flags(input int i);
        logic bs;
        bs = TS[i] ? ~TB[i][15] : TB[i][15];
        return {TR[i][15], TA[i][15] == bs && TR[i][15] != TA[i][15],
                TR[i] == 16'h0, TC[i]};
    endfunction

    task automatic pri_sweep(input logic h);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_STATUS, 4'h1, 32'(i << 5));
            ex[7:0] = 8'(i << 5);
            chk_sw();
            chk("eff", 32'({h, 3'(i)}), 32'(effective_priority));
            chk("blk", 32'(h || i == 7), 32'(user_irq_blocked));
        end
    endtask

    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        ex = 16'h0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk_sw();
        rd(OFS_CORE_CTRL, 32'h0);
        rd(OFS_INT_CTRL1, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            core.alu(TA[i], TB[i], TR[i], TC[i], TS[i], 4'hF, 1'b0);
            ex[3:0] = flags(i);
            chk_sw();
        end
        core.alu(16'h1, 16'h1, 16'h8002, 1'b0, 1'b0, 4'b0001, 1'b0);
        ex[0] = 1'b0;
        chk_sw();
        core.alu(16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 4'b0010, 1'b1);
        chk_sw();
        core.alu(16'h1, 16'h2, 16'h3, 1'b1, 1'b0, 4'b0010, 1'b1);
        ex[1] = 1'b0;
        chk_sw();
        core.alu(16'h0, 16'h0, 16'h0, 1'b1, 1'b0, 4'b0010, 1'b1);
        chk_sw();
        $display("test alu flags done");
        core.loop(1'b1);
        @(posedge sys_clk);
        ex[4] = 1'b1;
        chk_sw();
        wr(OFS_STATUS, 4'h1, 32'hA5);
        ex[7:0] = 8'hB5;
        chk_sw();
        core.loop(1'b0);
        @(posedge sys_clk);
        ex[4] = 1'b0;
        chk_sw();
        $display("test loop done");
        pri_sweep(1'b0);
        wr(OFS_CORE_CTRL, 4'h1, 32'hFFFFFFFF);
        rd(OFS_CORE_CTRL, 32'h8);
        pri_sweep(1'b1);
        wr(OFS_CORE_CTRL, 4'h1, 32'h0);
        $display("test priority done");
        wr(OFS_INT_CTRL1, 4'h2, 32'hFFFF);
        rd(OFS_INT_CTRL1, 32'h8000);
        wr(OFS_STATUS, 4'h1, 32'h40);
        chk_sw();
        core.hw(1'b1, 3'h3, 1'b0, 1'b0);
        ex[7:5] = 3'h3;
        chk_sw();
        wr(OFS_INT_CTRL1, 4'h2, 32'h0);
        wr(OFS_STATUS, 4'h1, 32'h40);
        ex[7:0] = 8'h40;
        chk_sw();
        $display("test nesting done");
        // high-byte writes only, never a read-modify-write
        core.hw(1'b0, 3'h0, 1'b1, 1'b1);
        ex[13:10] = 4'hD;
        chk_sw();
        wr(OFS_STATUS, 4'h2, 32'h3000);
        ex[13:10] = 4'h0;
        chk_sw();
        wr(OFS_STATUS, 4'h2, 32'h2000);
        ex[13:10] = 4'h9;
        chk_sw();
        core.hw(1'b0, 3'h0, 1'b0, 1'b1);
        wr(OFS_STATUS, 4'h2, 32'h1400);
        ex[13:10] = 4'h5;
        chk_sw();
        $display("test saturation done");
        wr(4'hC, 4'hF, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        rd(OFS_STATUS, 32'(ex));
        $display("test unmapped done");
        stop_test();
    end

    // hang guard, far beyond the hundred and forty or so cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
endmodule
